// ---- hw/qme_regs.svh ----
// Constants for the quadword ECC read-merge-write block
`ifndef QME_REGS_SVH
`define QME_REGS_SVH
`define QME_DATA_W 64
`define QME_CHK_W 8
`define QME_SYN_W 7
`define QME_BE_W 8
`define QME_BE_ALL 8'hFF
`define QME_CHK_NONE 8'h00
`define QME_ADDR_W 32
`endif

// ---- hw/qme_pkg.sv ----
// Types for the quadword ECC read-merge-write block
package qme_pkg;
  typedef enum logic [2:0] {
    QME_IDLE,
    QME_RD_ISSUE,
    QME_RD_WAIT,
    QME_WR_ISSUE,
    QME_RESP
  } qme_state_t;
endpackage

// ---- hw/qme_codec_if.sv ----
// Signals between the sequencer and the check-code codec
`timescale 1ns/1ps
`default_nettype none
`include "qme_regs.svh"
interface qme_codec_if;
  logic [`QME_DATA_W-1:0] enc_data;
  logic [`QME_CHK_W-1:0] enc_check;
  logic [`QME_DATA_W-1:0] dec_data;
  logic [`QME_CHK_W-1:0] dec_check;
  logic [`QME_DATA_W-1:0] dec_fixed;
  logic dec_ce;
  logic dec_ue;
  modport codec (input enc_data, dec_data, dec_check, output enc_check, dec_fixed, dec_ce, dec_ue);
  modport user (output enc_data, dec_data, dec_check, input enc_check, dec_fixed, dec_ce, dec_ue);
endinterface
`default_nettype wire

// ---- hw/qme_secded.sv ----
// Single-correct double-detect codec for one quadword and its check byte
`timescale 1ns/1ps
`default_nettype none
`include "qme_regs.svh"
module qme_secded (
  qme_codec_if.codec cif
);
  // Hamming position of data bit idx: skips power-of-two slots kept for check bits
  function automatic logic [`QME_SYN_W-1:0] qme_pos(input int idx);
    int n;
    logic [`QME_SYN_W-1:0] r;
    n = 0;
    r = '0;
    for (int p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == idx) r = 7'(p);
        n++;
      end
    end
    return r;
  endfunction

  logic [`QME_SYN_W-1:0] enc_p;
  logic [`QME_SYN_W-1:0] dec_p;
  logic [`QME_SYN_W-1:0] syn;
  logic [`QME_DATA_W-1:0] flip;
  logic ovr;

  // Parity sums over the positions of set bits, for both directions
  always_comb begin
    logic [`QME_SYN_W-1:0] pos_v;
    pos_v = '0;
    enc_p = '0;
    dec_p = '0;
    for (int i = 0; i < `QME_DATA_W; i++) begin
      pos_v = qme_pos(i); // Held in a variable: a function result cannot be bit-selected
      for (int k = 0; k < `QME_SYN_W; k++) begin
        if (pos_v[k]) begin
          enc_p[k] = enc_p[k] ^ cif.enc_data[i];
          dec_p[k] = dec_p[k] ^ cif.dec_data[i];
        end
      end
    end
  end

  // Top check bit is overall parity so that double errors stand apart
  assign cif.enc_check = {^{cif.enc_data, enc_p}, enc_p};
  assign syn = cif.dec_check[`QME_SYN_W-1:0] ^ dec_p;
  assign ovr = ^{cif.dec_data, cif.dec_check};

  // Flip the one data bit the syndrome points at
  always_comb begin
    flip = '0;
    for (int i = 0; i < `QME_DATA_W; i++) begin
      flip[i] = ovr && (syn == qme_pos(i));
    end
  end

  assign cif.dec_fixed = cif.dec_data ^ flip;
  assign cif.dec_ce = ovr; // Odd parity: one bit wrong, in data or check
  assign cif.dec_ue = !ovr && (syn != '0); // Even parity with syndrome: two bits wrong
endmodule // qme_secded
`default_nettype wire

// ---- hw/qme_top.sv ----
// Quadword ECC sequencer with read-merge-write for partial writes
`timescale 1ns/1ps
`default_nettype none
`include "qme_regs.svh"
module qme_top
  import qme_pkg::*;
#(
  parameter int ADDR_W = `QME_ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_ecc_enable,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [`QME_DATA_W-1:0] i_req_wdata,
  input wire logic [`QME_BE_W-1:0] i_req_be,
  output logic o_rsp_valid,
  output logic o_rsp_write,
  output logic [`QME_DATA_W-1:0] o_rsp_rdata,
  output logic o_rsp_ce,
  output logic o_rsp_ue,
  output logic o_ce_pulse,
  output logic o_ue_pulse,
  output logic o_mem_cmd_valid,
  input wire logic i_mem_cmd_ready,
  output logic o_mem_we,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [`QME_DATA_W-1:0] o_mem_wdata,
  output logic [`QME_CHK_W-1:0] o_mem_wcheck,
  output logic [`QME_BE_W-1:0] o_mem_be,
  input wire logic i_mem_rvalid,
  input wire logic [`QME_DATA_W-1:0] i_mem_rdata,
  input wire logic [`QME_CHK_W-1:0] i_mem_rcheck
);
  // Expand byte enables into a bit mask
  function automatic logic [`QME_DATA_W-1:0] qme_mask(input logic [`QME_BE_W-1:0] be);
    logic [`QME_DATA_W-1:0] m;
    m = '0;
    for (int b = 0; b < `QME_BE_W; b++) m[b*8 +: 8] = {8{be[b]}};
    return m;
  endfunction

  qme_codec_if cif ();
  qme_secded u_codec (.cif(cif));

  qme_state_t state_q, state_d;
  logic ecc_q;
  logic rmw_q;
  logic write_q;
  logic [ADDR_W-1:0] addr_q;
  logic [`QME_DATA_W-1:0] data_q, data_d;
  logic [`QME_CHK_W-1:0] check_q, check_d;
  logic [`QME_BE_W-1:0] be_q, be_d;
  logic rsp_ce_q, rsp_ue_q;
  logic ce_pulse_q, ue_pulse_q;

  wire accept = (state_q == QME_IDLE) && i_req_valid;
  wire partial = (i_req_be != `QME_BE_ALL);
  wire go_rmw = i_req_write && partial && i_ecc_enable;
  wire rd_done = (state_q == QME_RD_WAIT) && i_mem_rvalid;
  wire cmd_taken = o_mem_cmd_valid && i_mem_cmd_ready;
  wire [`QME_DATA_W-1:0] be_mask = qme_mask(be_q);
  wire [`QME_DATA_W-1:0] rd_clean = ecc_q ? cif.dec_fixed : i_mem_rdata;
  wire [`QME_DATA_W-1:0] merged = (data_q & be_mask) | (rd_clean & ~be_mask);
  wire hit_ce = rd_done && ecc_q && cif.dec_ce;
  wire hit_ue = rd_done && ecc_q && cif.dec_ue;

  // Codec sees the word about to be written and the word being read
  assign cif.enc_data = (state_q == QME_RD_WAIT) ? merged : i_req_wdata;
  assign cif.dec_data = i_mem_rdata;
  assign cif.dec_check = i_mem_rcheck;

  // Next state of the transfer sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      QME_IDLE: begin
        if (accept) state_d = (i_req_write && !go_rmw) ? QME_WR_ISSUE : QME_RD_ISSUE;
      end
      QME_RD_ISSUE: begin
        if (cmd_taken) state_d = QME_RD_WAIT;
      end
      QME_RD_WAIT: begin
        if (i_mem_rvalid) state_d = rmw_q ? QME_WR_ISSUE : QME_RESP;
      end
      QME_WR_ISSUE: begin
        if (cmd_taken) state_d = QME_RESP;
      end
      default: state_d = QME_IDLE;
    endcase
  end

  // Data and code loaded on accept and on every read return, merged or plain; lane selection on accept and on merge reads only
  always_comb begin
    data_d = data_q;
    check_d = check_q;
    be_d = be_q;
    if (accept) begin
      data_d = i_req_wdata;
      check_d = i_ecc_enable ? cif.enc_check : `QME_CHK_NONE;
      be_d = i_ecc_enable ? `QME_BE_ALL : i_req_be;
      if (go_rmw) be_d = i_req_be;
    end else if (rd_done) begin
      data_d = rmw_q ? merged : rd_clean;
      check_d = cif.enc_check;
      if (rmw_q) be_d = `QME_BE_ALL;
    end
  end

  // Sequencer registers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= QME_IDLE;
      ecc_q <= 1'b0;
      rmw_q <= 1'b0;
      write_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
      check_q <= `QME_CHK_NONE;
      be_q <= '0;
    end else begin
      state_q <= state_d;
      data_q <= data_d;
      check_q <= check_d;
      be_q <= be_d;
      if (accept) begin
        ecc_q <= i_ecc_enable;
        rmw_q <= go_rmw;
        write_q <= i_req_write;
        addr_q <= i_req_addr;
      end
    end
  end

  // Error flags: per-response levels and one-cycle event pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rsp_ce_q <= 1'b0;
      rsp_ue_q <= 1'b0;
      ce_pulse_q <= 1'b0;
      ue_pulse_q <= 1'b0;
    end else begin
      ce_pulse_q <= hit_ce;
      ue_pulse_q <= hit_ue;
      if (accept) begin
        rsp_ce_q <= 1'b0;
        rsp_ue_q <= 1'b0;
      end else if (rd_done) begin
        rsp_ce_q <= hit_ce;
        rsp_ue_q <= hit_ue;
      end
    end
  end

  // Port drive
  assign o_req_ready = (state_q == QME_IDLE);
  assign o_mem_cmd_valid = (state_q == QME_RD_ISSUE) || (state_q == QME_WR_ISSUE);
  assign o_mem_we = (state_q == QME_WR_ISSUE);
  assign o_mem_addr = addr_q;
  assign o_mem_wdata = data_q;
  assign o_mem_wcheck = check_q;
  assign o_mem_be = be_q;
  assign o_rsp_valid = (state_q == QME_RESP);
  assign o_rsp_write = write_q;
  assign o_rsp_rdata = data_q;
  assign o_rsp_ce = rsp_ce_q;
  assign o_rsp_ue = rsp_ue_q;
  assign o_ce_pulse = ce_pulse_q;
  assign o_ue_pulse = ue_pulse_q;

  // Checks on the sequence
  sequence s_merge_read;
    (state_q == QME_RD_WAIT) && i_mem_rvalid && rmw_q;
  endsequence

  sequence s_full_write;
    (state_q == QME_WR_ISSUE) && o_mem_we && (o_mem_be == `QME_BE_ALL);
  endsequence

  AST_FULL_WRITE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (o_mem_cmd_valid && o_mem_we && ecc_q) |-> (o_mem_be == `QME_BE_ALL))
    else $error("ECC write not a full quadword");

  AST_NO_CODE_OFF: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (o_mem_cmd_valid && o_mem_we && !ecc_q) |-> (o_mem_wcheck == `QME_CHK_NONE))
    else $error("Check code driven with ECC off");

  AST_RMW_START: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (accept && i_req_write && partial && i_ecc_enable) |=> (state_q == QME_RD_ISSUE) && !o_mem_we)
    else $error("Partial ECC write not started as read");

  AST_RMW_ORDER: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_merge_read |=> s_full_write)
    else $error("Merge read not followed by full write");

  AST_MERGE_KEEPS: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    s_merge_read |=> ((data_q & ~qme_mask($past(be_q))) == ($past(cif.dec_fixed) & ~qme_mask($past(be_q)))))
    else $error("Merged quadword lost corrected bytes");

  AST_CODE_OF_MERGE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (s_merge_read ##1 (state_q == QME_WR_ISSUE)) |-> (o_mem_wcheck == $past(cif.enc_check)))
    else $error("Merged write carries stale code");

  AST_UE_REPORT: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (rd_done && !rmw_q && ecc_q && cif.dec_ue) |=> o_rsp_valid && o_rsp_ue && o_ue_pulse)
    else $error("Two-bit error not reported");

  AST_CE_CAUSE: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    o_ce_pulse |-> $past(rd_done) && $past(ecc_q) && !o_ue_pulse)
    else $error("Corrected flag without a checked read");
endmodule // qme_top
`default_nettype wire

// ---- verification/qme_mem_model.sv ----
// Behavioural memory array answering the block's command and read-data strobes
`timescale 1ns/1ps
`default_nettype none
module qme_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic [71:0] i_flip,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [63:0] i_wdata,
  input wire logic [7:0] i_wcheck,
  input wire logic [7:0] i_be,
  output logic o_rvalid,
  output logic [63:0] o_rdata,
  output logic [7:0] o_rcheck
);
  logic [63:0] mem_d [logic [31:0]];
  logic [7:0] mem_c [logic [31:0]];
  logic [1:0] wait_q;
  logic pend_q;
  logic [31:0] pend_a_q;
  // A slow array stalls each command two cycles
  assign o_cmd_ready = i_cmd_valid && (wait_q == (i_slow ? 2'h2 : 2'h0));
  // Stores by byte lane; outside a strobe the data lines toggle so stale data never matches
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      wait_q <= 2'h0;
      pend_q <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 64'h0;
      o_rcheck <= 8'h0;
    end else begin
      o_rvalid <= 1'b0;
      o_rdata <= ~o_rdata;
      o_rcheck <= ~o_rcheck;
      if (i_cmd_valid && !o_cmd_ready) wait_q <= wait_q + 2'h1;
      if (o_cmd_ready) begin
        wait_q <= 2'h0;
        if (!mem_d.exists(i_addr)) begin
          mem_d[i_addr] = 64'h0;
          mem_c[i_addr] = 8'h0;
        end
        if (i_we) begin
          for (int b = 0; b < 8; b++) if (i_be[b]) mem_d[i_addr][8*b +: 8] = i_wdata[8*b +: 8];
          mem_c[i_addr] = i_wcheck;
        end else begin
          pend_q <= 1'b1;
          pend_a_q <= i_addr;
        end
      end
      if (pend_q) begin
        pend_q <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= mem_d[pend_a_q] ^ i_flip[63:0];
        o_rcheck <= mem_c[pend_a_q] ^ i_flip[71:64];
      end
    end
  end
endmodule // qme_mem_model
`default_nettype wire

// ---- verification/qword_ecc_read_merge_write_bench.sv ----
// Self-checking bench for the quadword ECC sequencer
`timescale 1ns/1ps
`default_nettype none
module qword_ecc_read_merge_write_bench;
  logic clk = 1'b0, srst = 1'b1, ecc = 1'b1, valid = 1'b0, wr = 1'b0, slow = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [63:0] wdata = 64'h0;
  logic [7:0] be = 8'h0;
  logic [71:0] flip = 72'h0;
  logic rdy, rsp_v, rsp_w, rsp_ce, rsp_ue, ce_p, ue_p, cv, cr, we, rv;
  logic [63:0] rsp_d, mwd, mrd;
  logic [7:0] mwc, mbe, mrc;
  logic [31:0] maddr;
  logic ce_seen, ue_seen;
  logic [1:0] ord;
  logic [7:0] seen_be, seen_chk;
  int rd_n, wr_n, miscompares = 0, n_tests = 0;
  localparam logic [63:0] DA = 64'hDEAD_BEEF_0123_4567;
  localparam logic [63:0] NW = 64'h1111_2222_3333_4444;
  always #5 clk = ~clk;
  qme_top qme_top_inst (.i_ref_clk(clk), .i_srst(srst), .i_ecc_enable(ecc), .i_req_valid(valid),
    .o_req_ready(rdy), .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wdata), .i_req_be(be),
    .o_rsp_valid(rsp_v), .o_rsp_write(rsp_w), .o_rsp_rdata(rsp_d), .o_rsp_ce(rsp_ce), .o_rsp_ue(rsp_ue),
    .o_ce_pulse(ce_p), .o_ue_pulse(ue_p), .o_mem_cmd_valid(cv), .i_mem_cmd_ready(cr), .o_mem_we(we),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_wcheck(mwc), .o_mem_be(mbe), .i_mem_rvalid(rv),
    .i_mem_rdata(mrd), .i_mem_rcheck(mrc));
  qme_mem_model qme_mem_model_inst (.i_ref_clk(clk), .i_srst(srst), .i_slow(slow), .i_flip(flip),
    .i_cmd_valid(cv), .o_cmd_ready(cr), .i_we(we), .i_addr(maddr), .i_wdata(mwd), .i_wcheck(mwc),
    .i_be(mbe), .o_rvalid(rv), .o_rdata(mrd), .o_rcheck(mrc));
  // Records every memory command and error pulse of the current transfer
  always @(posedge clk) begin
    if (!srst && cv && cr) begin
      ord <= {ord[0], we};
      if (we) begin
        wr_n <= wr_n + 1;
        seen_be <= mbe;
        seen_chk <= mwc;
      end else rd_n <= rd_n + 1;
    end
    if (ce_p === 1'b1) ce_seen <= 1'b1;
    if (ue_p === 1'b1) ue_seen <= 1'b1;
  end
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One host request held until accepted, then waits for its response
  task automatic req(input logic w, input logic [63:0] d, input logic [7:0] b);
    int n;
    @(posedge clk);
    #1;
    {valid, wr, wdata, be, ce_seen, ue_seen, rd_n, wr_n, ord} = {1'b1, w, d, b, 2'b00, 64'd0, 2'b00};
    // Ready is looked at once it has settled, so the next edge is the accepting one
    while (rdy !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    valid = 1'b0;
    n = 0;
    while (rsp_v !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (rsp_v !== 1'b1) chk("response", 64'h1, 64'h0);
    // One more edge so the recorder has caught the error pulses of this response
    @(posedge clk);
    #1;
  endtask
  task automatic t_full;
    req(1'b1, DA, 8'hFF);
    chk("full write reads", 64'h0, 64'(rd_n));
    chk("full write be", 64'hFF, 64'(seen_be));
    chk("write flag", 64'h1, 64'(rsp_w));
    req(1'b0, 64'h0, 8'h0);
    chk("read back", DA, rsp_d);
    chk("read flag", 64'h0, 64'(rsp_w));
    chk("clean flags", 64'h0, {rsp_ce, rsp_ue, ce_seen, ue_seen});
    $display("t_full done");
  endtask
  task automatic t_errors;
    int bits [4] = '{0, 37, 63, 70};
    foreach (bits[i]) begin
      flip = 72'h1 << bits[i];
      req(1'b0, 64'h0, 8'h0);
      chk("corrected data", DA, rsp_d);
      chk("single flags", 64'hA, {rsp_ce, rsp_ue, ce_seen, ue_seen});
    end
    flip = (72'h1 << 3) | (72'h1 << 50);
    req(1'b0, 64'h0, 8'h0);
    chk("double flags", 64'h5, {rsp_ce, rsp_ue, ce_seen, ue_seen});
    flip = 72'h0;
    $display("t_errors done");
  endtask
  task automatic t_rmw;
    slow = 1'b1;
    flip = 72'h1 << 40;
    req(1'b1, NW, 8'h0F);
    chk("merge order", 64'h1, 64'(ord));
    chk("merge reads", 64'h1, 64'(rd_n));
    chk("merge be", 64'hFF, 64'(seen_be));
    chk("merge ce", 64'h2, {rsp_ce, rsp_ue});
    flip = 72'h0;
    slow = 1'b0;
    req(1'b0, 64'h0, 8'h0);
    chk("merged data", {DA[63:32], NW[31:0]}, rsp_d);
    chk("merged clean", 64'h0, {rsp_ce, rsp_ue});
    $display("t_rmw done");
  endtask
  // Reset in the middle of a read, then a second word proves the address reaches memory
  task automatic t_reset;
    @(posedge clk);
    #1;
    {valid, wr, be} = {1'b1, 1'b0, 8'h00};
    @(posedge clk);
    #1;
    valid = 1'b0;
    srst = 1'b1;
    chk("busy ready", 64'h0, 64'(rdy));
    @(posedge clk);
    #1;
    chk("reset outputs", 64'h80, {rdy, cv, rsp_v, ce_p, ue_p, we, rsp_ce, rsp_ue});
    chk("reset data", 64'h0, rsp_d);
    @(posedge clk);
    #1;
    srst = 1'b0;
    addr = 32'h40;
    req(1'b1, NW, 8'hFF);
    addr = 32'h0;
    req(1'b0, 64'h0, 8'h0);
    chk("other word kept", {DA[63:32], NW[31:0]}, rsp_d);
    addr = 32'h40;
    req(1'b0, 64'h0, 8'h0);
    chk("other word", NW, rsp_d);
    addr = 32'h0;
    $display("t_reset done");
  endtask
  task automatic t_off;
    ecc = 1'b0;
    req(1'b1, NW, 8'hF0);
    chk("off reads", 64'h0, 64'(rd_n));
    chk("off be", 64'hF0, 64'(seen_be));
    chk("off check", 64'h0, 64'(seen_chk));
    req(1'b0, 64'h0, 8'h0);
    chk("off data", {NW[63:32], NW[31:0]}, rsp_d);
    ecc = 1'b1;
    $display("t_off done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    t_full;
    t_errors;
    t_rmw;
    t_reset;
    t_off;
    stop_test;
  end
endmodule // qword_ecc_read_merge_write_bench
`default_nettype wire
